// ---- mon_pkg.sv ----
// Package with register map, field layout and carrier types for the monitor
package mon_pkg;

  localparam logic [7:0] MON_ADDR_DIE_TEMP = 8'h06;
  localparam logic [7:0] MON_ADDR_CURRENT = 8'h07;
  localparam logic [7:0] MON_ADDR_POWER = 8'h08;
  localparam logic [7:0] MON_ADDR_DIAG = 8'h0b;

  localparam int MON_ADDR_W = 8;
  localparam int MON_REG_W = 16;
  localparam int MON_RDATA_W = 24;
  localparam int MON_TEMP_W = 12;
  localparam int MON_TEMP_LSB = 4;
  localparam int MON_POWER_W = 24;
  localparam int MON_BUS_W = 15;
  localparam int MON_LIM_W = 6;

  // Diagnostic and alert register bit positions
  localparam int MON_BIT_HOLD = 15;
  localparam int MON_BIT_RDY_ALERT = 14;
  localparam int MON_BIT_AVG_CMP = 13;
  localparam int MON_BIT_POL = 12;
  localparam int MON_BIT_OVF = 9;
  localparam int MON_BIT_LIM_HI = 7;
  localparam int MON_BIT_LIM_LO = 2;
  localparam int MON_BIT_DONE = 1;
  localparam int MON_BIT_TRIM = 0;

  // Limit vector order, index into bits 7 to 2
  localparam int MON_LIM_TEMP = 5;
  localparam int MON_LIM_SHUNT_OV = 4;
  localparam int MON_LIM_SHUNT_UN = 3;
  localparam int MON_LIM_BUS_OV = 2;
  localparam int MON_LIM_BUS_UN = 1;
  localparam int MON_LIM_POWER = 0;

  localparam logic [15:0] MON_DIAG_RESET = 16'h0001;
  localparam logic [11:0] MON_TEMP_RESET = 12'h000;
  localparam logic [15:0] MON_CURRENT_RESET = 16'h0000;
  localparam logic [23:0] MON_POWER_RESET = 24'h000000;

  typedef struct packed {
    logic [11:0] temp;
    logic [15:0] current;
    logic [23:0] power;
    logic [15:0] shunt;
    logic [15:0] bus;
  } mon_meas_t;

  typedef struct packed {
    logic [11:0] temp_hi;
    logic [15:0] shunt_hi;
    logic [15:0] shunt_lo;
    logic [14:0] bus_hi;
    logic [14:0] bus_lo;
    logic [23:0] power_hi;
  } mon_limits_t;

  typedef struct packed {
    logic hold_mode;
    logic ready_on_alert;
    logic compare_avg;
    logic polarity;
  } mon_cfg_t;

endpackage : mon_pkg

// ---- mon_limit_cmp.sv ----
// Limit comparators for temperature, shunt, bus and power results
`timescale 1ns/1ps
`default_nettype none
module mon_limit_cmp
  import mon_pkg::*;
(
  input wire mon_pkg::mon_meas_t meas,
  input wire mon_pkg::mon_limits_t lim,
  output logic [mon_pkg::MON_LIM_W-1:0] viol
);

  function automatic logic sgt16(input logic [15:0] a, input logic [15:0] b);
    sgt16 = $signed(a) > $signed(b);
  endfunction : sgt16

  always_comb begin
    viol = '0;
    // Same two's complement field on both sides, sign extended
    viol[MON_LIM_TEMP] = sgt16({{4{meas.temp[11]}}, meas.temp},
                               {{4{lim.temp_hi[11]}}, lim.temp_hi});
    viol[MON_LIM_SHUNT_OV] = sgt16(meas.shunt, lim.shunt_hi);
    viol[MON_LIM_SHUNT_UN] = sgt16(lim.shunt_lo, meas.shunt);
    // Bus result is never negative, so the low 15 bits suffice
    viol[MON_LIM_BUS_OV] = meas.bus[14:0] > lim.bus_hi;
    viol[MON_LIM_BUS_UN] = meas.bus[14:0] < lim.bus_lo;
    viol[MON_LIM_POWER] = meas.power > lim.power_hi;
  end

endmodule : mon_limit_cmp
`default_nettype wire

// ---- mon_results_alert.sv ----
// Result registers, diagnostic flags and alert pin of the power monitor
`timescale 1ns/1ps
`default_nettype none
module mon_results_alert
  import mon_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [mon_pkg::MON_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [mon_pkg::MON_REG_W-1:0] reg_wdata,
  output logic [mon_pkg::MON_RDATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire mon_pkg::mon_meas_t meas,
  input wire logic raw_valid,
  input wire logic avg_valid,
  input wire logic conv_start,
  input wire logic overflow_event,
  input wire logic trim_error,
  input wire mon_pkg::mon_limits_t limits,
  output logic alert_out,
  output logic alert_oe,
  output logic [mon_pkg::MON_REG_W-1:0] diag_value
);

  logic [MON_TEMP_W-1:0] temp_q;
  logic [15:0] current_q;
  logic [MON_POWER_W-1:0] power_q;
  mon_cfg_t cfg_q;
  logic [MON_LIM_W-1:0] lim_flags_q;
  logic ovf_q;
  logic done_q;
  logic trim_ok_q;
  logic [MON_LIM_W-1:0] viol;
  logic eval;
  logic diag_rd;
  logic diag_wr;
  logic [MON_REG_W-1:0] diag_word;
  logic alert_active;

  mon_limit_cmp u_cmp (
    .meas(meas),
    .lim(limits),
    .viol(viol)
  );

  function automatic logic addr_is(input logic [MON_ADDR_W-1:0] a,
                                   input logic [MON_ADDR_W-1:0] b);
    addr_is = a == b;
  endfunction : addr_is

  assign diag_rd = reg_rd && addr_is(reg_addr, MON_ADDR_DIAG);
  assign diag_wr = reg_wr && addr_is(reg_addr, MON_ADDR_DIAG);

  // Raw samples arrive often; averaged compare delays alerts until done
  assign eval = cfg_q.compare_avg ? avg_valid : raw_valid;

  // Results are taken only from completed conversions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_q <= MON_TEMP_RESET;
      current_q <= MON_CURRENT_RESET;
      power_q <= MON_POWER_RESET;
    end else if (avg_valid) begin
      temp_q <= meas.temp;
      current_q <= meas.current;
      power_q <= meas.power;
    end
  end

  // Configuration bits 15 to 12 of the diagnostic register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q.hold_mode <= MON_DIAG_RESET[MON_BIT_HOLD];
      cfg_q.ready_on_alert <= MON_DIAG_RESET[MON_BIT_RDY_ALERT];
      cfg_q.compare_avg <= MON_DIAG_RESET[MON_BIT_AVG_CMP];
      cfg_q.polarity <= MON_DIAG_RESET[MON_BIT_POL];
    end else if (diag_wr) begin
      cfg_q.hold_mode <= reg_wdata[MON_BIT_HOLD];
      cfg_q.ready_on_alert <= reg_wdata[MON_BIT_RDY_ALERT];
      cfg_q.compare_avg <= reg_wdata[MON_BIT_AVG_CMP];
      cfg_q.polarity <= reg_wdata[MON_BIT_POL];
    end
  end

  // Limit flags; a fault seen in the cycle of a clearing read survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lim_flags_q <= MON_DIAG_RESET[MON_BIT_LIM_HI:MON_BIT_LIM_LO];
    end else if (cfg_q.hold_mode) begin
      if (eval) begin
        lim_flags_q <= (diag_rd ? '0 : lim_flags_q) | viol;
      end else if (diag_rd) begin
        lim_flags_q <= '0;
      end
    end else if (eval) begin
      lim_flags_q <= viol;
    end
  end

  // Overflow flag: no software clear, only a new conversion clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_q <= MON_DIAG_RESET[MON_BIT_OVF];
    end else if (overflow_event) begin
      ovf_q <= 1'b1;
    end else if (conv_start) begin
      ovf_q <= 1'b0;
    end
  end

  // Conversion done flag; completion wins over any clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= MON_DIAG_RESET[MON_BIT_DONE];
    end else if (avg_valid) begin
      done_q <= 1'b1;
    end else if (conv_start || (cfg_q.hold_mode && diag_rd)) begin
      done_q <= 1'b0;
    end
  end

  // Trim status: an error forces zero over a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_ok_q <= MON_DIAG_RESET[MON_BIT_TRIM];
    end else if (trim_error) begin
      trim_ok_q <= 1'b0;
    end else if (diag_wr) begin
      trim_ok_q <= reg_wdata[MON_BIT_TRIM];
    end
  end

  always_comb begin
    diag_word = '0;
    diag_word[MON_BIT_HOLD] = cfg_q.hold_mode;
    diag_word[MON_BIT_RDY_ALERT] = cfg_q.ready_on_alert;
    diag_word[MON_BIT_AVG_CMP] = cfg_q.compare_avg;
    diag_word[MON_BIT_POL] = cfg_q.polarity;
    diag_word[MON_BIT_OVF] = ovf_q;
    diag_word[MON_BIT_LIM_HI:MON_BIT_LIM_LO] = lim_flags_q;
    diag_word[MON_BIT_DONE] = done_q;
    diag_word[MON_BIT_TRIM] = trim_ok_q;
  end

  // Read port; unmapped addresses answer zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          MON_ADDR_DIE_TEMP:
            reg_rdata <= {8'h00, temp_q, 4'h0};
          MON_ADDR_CURRENT: reg_rdata <= {8'h00, current_q};
          MON_ADDR_POWER: reg_rdata <= power_q;
          MON_ADDR_DIAG: reg_rdata <= {8'h00, diag_word};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  assign alert_active = (|lim_flags_q)
                        || (cfg_q.ready_on_alert && done_q);

  // Open-drain pin: only ever pulls low, polarity picks when
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
      diag_value <= MON_DIAG_RESET;
    end else begin
      alert_out <= 1'b0;
      alert_oe <= alert_active ^ cfg_q.polarity;
      diag_value <= diag_word;
    end
  end

endmodule : mon_results_alert
`default_nettype wire

// ---- mon_results_alert_properties.sv ----
// Checker for register reads, flags and alert pin of the monitor
`timescale 1ns/1ps
`default_nettype none
module mon_results_alert_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [23:0] reg_rdata,
  input wire logic raw_valid,
  input wire logic avg_valid,
  input wire logic conv_start,
  input wire logic overflow_event,
  input wire logic trim_error,
  input wire logic alert_oe,
  input wire logic [15:0] diag_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic act;
  // Alert cause seen through the delayed copy, same lag as the pin
  assign act = (|diag_value[7:2]) | (diag_value[14] & diag_value[1]);
  a_temp_low_zero:
    assert property (reg_rd && reg_addr == 8'h06 |=>
      reg_rdata[3:0] == 4'h0 && reg_rdata[23:16] == 8'h00)
    else $error("temperature low bits not zero");
  a_diag_readback:
    assert property (reg_rd && reg_addr == 8'h0b |=>
      reg_rdata == {8'h00, diag_value})
    else $error("diag read differs from register");
  a_rsvd_zero:
    assert property (diag_value[11:10] == 2'b00 && !diag_value[8])
    else $error("reserved diag bits set");
  a_ovf_set:
    assert property (overflow_event |-> ##2 diag_value[9])
    else $error("overflow flag not set");
  a_ovf_clear:
    assert property ($fell(diag_value[9]) |-> $past(conv_start, 2))
    else $error("overflow flag cleared without conversion");
  a_done_set:
    assert property (avg_valid |-> ##2 diag_value[1])
    else $error("done flag not set");
  a_hold_clear:
    assert property (reg_rd && reg_addr == 8'h0b && diag_value[15] &&
      !reg_wr && !$past(reg_wr) && !raw_valid && !avg_valid
      |-> ##2 diag_value[7:1] == 7'h00)
    else $error("hold read did not clear flags");
  a_trim_flag:
    assert property (trim_error |-> ##2 !diag_value[0])
    else $error("trim status not cleared");
  a_alert_level:
    assert property (alert_oe == (act ^ diag_value[12]))
    else $error("alert pin level wrong");
  c_hold_read: cover property (reg_rd && reg_addr == 8'h0b && diag_value[15]);
  c_ovf_clear: cover property ($fell(diag_value[9]));
  c_alert_rise: cover property ($rose(alert_oe));
endmodule : mon_results_alert_properties
`default_nettype wire

// ---- mon_host_model.sv ----
// Serial host model issuing single register reads and writes
`timescale 1ns/1ps
`default_nettype none
module mon_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [15:0] wd, output logic [23:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = !w;
    reg_wr = w;
    reg_wdata = wd;
    @(posedge clk);
    #1;
    d = reg_rvalid ? reg_rdata : 24'hxxxxxx;
    // Released lines flip so stale values cannot pass as held ones
    reg_addr = ~a;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = ~wd;
  endtask : xfer
endmodule : mon_host_model
`default_nettype wire

// ---- mon_results_alert_tb.sv ----
// Self-checking bench for result registers, flags and alert pin
`timescale 1ns/1ps
`default_nettype none
module mon_results_alert_tb;
  import mon_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] ev = 5'h00;
  mon_meas_t meas;
  mon_limits_t lim;
  logic [7:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic [23:0] reg_rdata;
  logic reg_rvalid;
  logic alert_out;
  logic alert_oe;
  logic [15:0] diag_value;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  initial forever #2 clk = ~clk;
  mon_results_alert mon_results_alert_i (.clk, .rst, .reg_addr, .reg_rd,
    .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid, .meas,
    .raw_valid(ev[0]), .avg_valid(ev[1]), .conv_start(ev[2]),
    .overflow_event(ev[3]), .trim_error(ev[4]), .limits(lim),
    .alert_out, .alert_oe, .diag_value);
  mon_host_model mon_host_model_i (.clk, .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata, .reg_rdata, .reg_rvalid);
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // Pin data must stay low; only the enable may move
  task automatic chk_pin(input logic e);
    @(posedge clk);
    #1;
    n_checks++;
    if ({alert_out, alert_oe} !== {1'b0, e}) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, {1'b0, e},
               {alert_out, alert_oe});
    end
  endtask : chk_pin
  task automatic rc(input logic [7:0] a, input logic [23:0] e);
    logic [23:0] g;
    mon_host_model_i.xfer(a, 1'b0, 16'h0000, g);
    chk(e, g);
  endtask : rc
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [23:0] g;
    mon_host_model_i.xfer(a, 1'b1, v, g);
  endtask : wr
  task automatic pulse(input int b);
    @(posedge clk);
    #1;
    ev[b] = 1'b1;
    @(posedge clk);
    #1;
    ev = 5'h00;
  endtask : pulse
  // Every compared field sits exactly on one of its limits, so nothing may trip
  task automatic nom;
    meas = '{12'h100, 16'h0000, 24'h001000, 16'hff00, 16'h0010};
  endtask : nom
  task automatic t_reset;
    rc(8'h0b, 24'h000001);
    rc(8'h06, 24'h000000);
    rc(8'h07, 24'h000000);
    rc(8'h08, 24'h000000);
    rc(8'h0c, 24'h000000);
    chk(24'h000001, {8'h00, diag_value});
    chk_pin(1'b0);
  endtask : t_reset
  task automatic t_results;
    meas = '{12'h9ab, 16'h8123, 24'hfedcba, 16'h0000, 16'h0020};
    pulse(1);
    rc(8'h06, 24'h009ab0);
    wr(8'h07, 16'h1234);
    rc(8'h07, 24'h008123);
    rc(8'h08, 24'hfedcba);
    rc(8'h0b, 24'h000003);
    pulse(2);
    rc(8'h0b, 24'h000001);
  endtask : t_results
  task automatic t_limits;
    logic [23:0] e;
    for (int i = 0; i < 6; i++) begin
      nom();
      case (i)
        0: meas.temp = 12'h101;
        1: meas.shunt = 16'h0101;
        2: meas.shunt = 16'hfeff;
        3: meas.bus = 16'h0101;
        4: meas.bus = 16'h000f;
        default: meas.power = 24'h001001;
      endcase
      pulse(0);
      e = 24'h000001 | (24'h80 >> i);
      rc(8'h0b, e);
      chk_pin(1'b1);
      nom();
      pulse(0);
      rc(8'h0b, 24'h000001);
      chk_pin(1'b0);
    end
  endtask : t_limits
  task automatic t_hold;
    wr(8'h0b, 16'hdfff);
    rc(8'h0b, 24'h00d001);
    chk_pin(1'b1);
    meas.temp = 12'h101;
    pulse(0);
    nom();
    pulse(0);
    chk_pin(1'b0);
    rc(8'h0b, 24'h00d081);
    chk_pin(1'b1);
    rc(8'h0b, 24'h00d001);
    pulse(1);
    chk_pin(1'b0);
    rc(8'h0b, 24'h00d003);
    rc(8'h0b, 24'h00d001);
  endtask : t_hold
  task automatic t_avg_flags;
    wr(8'h0b, 16'h2001);
    meas.temp = 12'h101;
    pulse(0);
    chk_pin(1'b0);
    rc(8'h0b, 24'h002001);
    pulse(1);
    chk_pin(1'b1);
    rc(8'h0b, 24'h002083);
    pulse(3);
    rc(8'h0b, 24'h002283);
    pulse(2);
    rc(8'h0b, 24'h002081);
    pulse(4);
    rc(8'h0b, 24'h002080);
  endtask : t_avg_flags
  initial begin
    nom();
    lim = '{12'h100, 16'h0100, 16'hff00, 15'h0100, 15'h0010, 24'h001000};
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_results();
    t_limits();
    t_hold();
    t_avg_flags();
    report_and_stop();
  end
  // Whole run needs about 150 cycles; this cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
endmodule : mon_results_alert_tb
bind mon_results_alert mon_results_alert_properties chk_i (.clk, .rst,
  .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .raw_valid, .avg_valid,
  .conv_start, .overflow_event, .trim_error, .alert_oe, .diag_value);
`default_nettype wire
